//--- rtl/wpsc_pkg.sv
// Summary of operation
// - watchdog counts internal RC oscillator ticks, not the system clock
// - fuse enable bit set forces the watchdog on; erased fuse reads 1
// - enabled watchdog counts to overflow; overflow in Run resets, in Idle wakes
// - overflow in Sleep wakes the device and sets Sleep and timeout flags
// - with fuse bit clear, soft enable bit 5 of reset control gates watchdog
// - bit 12 enables low-voltage detect, bits 11:8 level, bit 13 ref stable
// - power-save instruction enters Sleep or Idle per its operand
// - Sleep stops CPU, peripheral, oscillator clocks; RC kept for watchdog
// - low-voltage detect stays on in Sleep; clock fail monitor is off
// - Sleep ends on enabled interrupt, any reset, or watchdog overflow
// - wake restarts prior clock; with switching on, from oscillator field
// - crystal wake: startup timer or PLL lock, plus power-on, lock, powerup
// - RC or external clock wake applies only the power-on delay
// - low-power crystal kept running applies only the power-on delay
// - interrupt wake branches to handler and sets Sleep flag
// - any reset wakes Sleep and sets Sleep flag; power-on clears it
// - crystal wake clock dead after delays: monitor on traps to fast RC, else stall
// - Idle stops only CPU clock; wake resumes at once after instruction
// - Idle wake sets Idle flag; watchdog wake also sets timeout flag
// - module disable bit stops peripheral clock; runs if clear and present
// - module disable change takes effect one instruction cycle after write
package wpsc_pkg;
    // ****************************************************
    // register addresses
    // ****************************************************
    localparam logic [15:0] RESET_CONTROL_REG_ADDR = 16'h0740;
    localparam logic [15:0] OSC_CONTROL_REG_ADDR = 16'h0742;
    localparam logic [15:0] MODULE_DISABLE1_ADDR = 16'h0770;
    localparam logic [15:0] MODULE_DISABLE2_ADDR = 16'h0772;
    localparam logic [23:0] OSCILLATOR_CONFIG_WORD_ADDR = 24'hF80000;
    localparam logic [23:0] WATCHDOG_CONFIG_WORD_ADDR = 24'hF80002;
    localparam logic [23:0] RESET_SUPPLY_CONFIG_WORD_ADDR = 24'hF80004;
    localparam logic [23:0] CODE_SEGMENT_CONFIG_WORD_ADDR = 24'hF8000A;
    // ****************************************************
    // field positions
    // ****************************************************
    localparam int WATCHDOG_FUSE_ENABLE_BIT = 15;
    localparam int OSC_SELECT_LSB = 8;
    localparam int REF_STABLE_BIT = 13;
    localparam int LOWVOLT_ENABLE_BIT = 12;
    localparam int LOWVOLT_LEVEL_LSB = 8;
    localparam int SOFT_ENABLE_BIT = 5;
    localparam int TIMEOUT_FLAG_BIT = 4;
    localparam int SLEEP_FLAG_BIT = 3;
    localparam int IDLE_FLAG_BIT = 2;
    localparam int BROWNOUT_FLAG_BIT = 1;
    localparam int POWER_ON_FLAG_BIT = 0;
    localparam int CUR_OSC_LSB = 12;
    localparam int LOCK_BIT = 5;
    localparam int CLOCK_FAIL_BIT = 3;
    localparam int KEEP_RUN_BIT = 1;
    localparam logic [15:0] RESET_CONTROL_RESET = 16'h0003;
    localparam logic [15:0] RESET_CONTROL_WMASK = 16'hDFFF;
    // ****************************************************
    // oscillator codes of the current oscillator field
    // ****************************************************
    localparam logic [1:0] OSC_FAST_RC = 2'h0;
    localparam logic [1:0] OSC_LOW_POWER_CRYSTAL = 2'h1;
    localparam logic [1:0] OSC_RC_OR_EXTERNAL = 2'h2;
    localparam logic [1:0] OSC_PRIMARY_CRYSTAL = 2'h3;
    // ****************************************************
    // timing
    // ****************************************************
    localparam int CLK_PERIOD_NS = 40;
    localparam int POWER_ON_DELAY_NS = 10000;
    localparam int POWERUP_TIMER_DELAY_NS = 16000;
    localparam int PLL_SETTLE_DELAY_NS = 20000;
    localparam int REF_SETTLE_NS = 20000;
    localparam logic [15:0] POWER_ON_CYC =
        16'((POWER_ON_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] POWERUP_CYC =
        16'((POWERUP_TIMER_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] PLL_SETTLE_CYC =
        16'((PLL_SETTLE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [9:0] REF_SETTLE_CYC =
        10'((REF_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // ****************************************************
    // power states
    // ****************************************************
    typedef enum logic [2:0] {
        ST_RUN = 3'h0,
        ST_IDLE = 3'h1,
        ST_SLEEP = 3'h2,
        ST_WAKE = 3'h3,
        ST_STALL = 3'h4
    } wpsc_state_t;
endpackage

//--- rtl/wpsc_top.sv
`timescale 1ns/100ps
`default_nettype none
module wpsc_top
    import wpsc_pkg::*;
#(
    parameter logic [15:0] WDT_PERIOD = 16'h0200,
    parameter logic [31:0] PERIPH_PRESENT = 32'hFFFFFFFF
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    // special function register port
    input wire logic [15:0] sfr_addr_i,
    input wire logic [15:0] sfr_wdata_i,
    input wire logic sfr_we_i,
    input wire logic sfr_re_i,
    output logic [15:0] sfr_rdata_o,
    // configuration words
    input wire logic [23:0] watchdog_config_word_i,
    input wire logic [23:0] oscillator_config_word_i,
    // instructions and events from the core
    input wire logic watchdog_clear_instr_i,
    input wire logic power_save_instr_i,
    input wire logic power_save_idle_i,
    input wire logic irq_wake_i,
    input wire logic other_reset_i,
    input wire logic rc_tick_i,
    // oscillator status
    input wire logic clock_switch_en_i,
    input wire logic clock_fail_monitor_en_i,
    input wire logic osc_stable_i,
    input wire logic pll_used_i,
    input wire logic pll_lock_i,
    // clock gating and status
    output logic cpu_clk_en_o,
    output logic periph_clk_en_o,
    output logic osc_en_o,
    output logic low_power_rc_en_o,
    output logic clock_fail_monitor_active_o,
    output logic [1:0] wake_osc_o,
    output logic [31:0] module_clk_en_o,
    // low-voltage detect
    output logic lowvolt_enable_o,
    output logic [3:0] lowvolt_level_o,
    // events
    output logic device_reset_o,
    output logic clock_fail_trap_o,
    output logic resume_o,
    output logic irq_service_o
);
    // ****************************************************
    // state
    // ****************************************************
    typedef struct packed {
        wpsc_state_t st;
        logic [15:0] wdt;
        logic [15:0] dly;
        logic [9:0] ref_cnt;
        logic [15:0] rst_ctrl;
        logic [1:0] osc_sel;
        logic keep_run;
        logic cf;
        logic [15:0] mdis_lo;
        logic [15:0] mdis_hi;
        logic [31:0] mdis_eff;
        logic [15:0] rdata;
        logic svc_pend;
        logic sys_rst;
        logic trap;
        logic resume;
        logic irq_svc;
    } wpsc_reg_t;

    localparam wpsc_reg_t REG_RESET = '{
        st: ST_RUN, rst_ctrl: RESET_CONTROL_RESET, default: '0};

    logic [1:0] rst_q;
    logic srst_n;
    wpsc_reg_t r;
    wpsc_reg_t next_r;
    logic wdt_en;
    logic ovf;
    logic slow_osc;
    logic clk_ok;
    logic wake_any;
    logic [15:0] wake_cyc;
    logic [15:0] osc_rd;

    // ****************************************************
    // reset release
    // ****************************************************
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign srst_n = rst_q[1];

    // ****************************************************
    // derived terms
    // ****************************************************
    assign wdt_en = watchdog_config_word_i[WATCHDOG_FUSE_ENABLE_BIT]
        | r.rst_ctrl[SOFT_ENABLE_BIT];
    assign ovf = wdt_en && rc_tick_i && (r.wdt == WDT_PERIOD - 16'h1);
    assign slow_osc = (r.osc_sel == OSC_PRIMARY_CRYSTAL)
        || (r.osc_sel == OSC_LOW_POWER_CRYSTAL && !r.keep_run);
    assign clk_ok = osc_stable_i && (!pll_used_i || pll_lock_i);
    assign wake_any = ovf || irq_wake_i || other_reset_i;
    assign wake_cyc = slow_osc
        ? 16'(POWER_ON_CYC + POWERUP_CYC
              + (pll_used_i ? PLL_SETTLE_CYC : 16'h0))
        : POWER_ON_CYC;
    assign osc_rd = {2'h0, r.osc_sel, 6'h0, pll_lock_i, 1'b0, r.cf, 1'b0,
        r.keep_run, 1'b0};

    // ****************************************************
    // next state
    // ****************************************************
    always_comb begin
        next_r = r;
        next_r.sys_rst = 1'b0;
        next_r.trap = 1'b0;
        next_r.resume = 1'b0;
        next_r.irq_svc = 1'b0;
        if (sfr_we_i) begin
            case (sfr_addr_i)
                RESET_CONTROL_REG_ADDR: begin
                    next_r.rst_ctrl = (sfr_wdata_i & RESET_CONTROL_WMASK)
                        | (r.rst_ctrl & ~RESET_CONTROL_WMASK);
                end
                OSC_CONTROL_REG_ADDR: begin
                    next_r.keep_run = sfr_wdata_i[KEEP_RUN_BIT];
                    next_r.cf = sfr_wdata_i[CLOCK_FAIL_BIT];
                end
                MODULE_DISABLE1_ADDR: next_r.mdis_lo = sfr_wdata_i;
                MODULE_DISABLE2_ADDR: next_r.mdis_hi = sfr_wdata_i;
                default: ;
            endcase
        end
        if (sfr_re_i) begin
            case (sfr_addr_i)
                RESET_CONTROL_REG_ADDR: next_r.rdata = r.rst_ctrl;
                OSC_CONTROL_REG_ADDR: next_r.rdata = osc_rd;
                MODULE_DISABLE1_ADDR: next_r.rdata = r.mdis_lo;
                MODULE_DISABLE2_ADDR: next_r.rdata = r.mdis_hi;
                default: next_r.rdata = 16'h0000;
            endcase
        end
        next_r.mdis_eff = {r.mdis_hi, r.mdis_lo};
        if (!clock_switch_en_i) begin
            next_r.osc_sel =
                oscillator_config_word_i[OSC_SELECT_LSB +: 2];
        end
        // reference settling
        if (!r.rst_ctrl[LOWVOLT_ENABLE_BIT]) begin
            next_r.ref_cnt = 10'h000;
            next_r.rst_ctrl[REF_STABLE_BIT] = 1'b0;
        end else if (r.ref_cnt == REF_SETTLE_CYC) begin
            next_r.rst_ctrl[REF_STABLE_BIT] = 1'b1;
        end else begin
            next_r.ref_cnt = r.ref_cnt + 10'h001;
        end
        // watchdog count
        if (!wdt_en || watchdog_clear_instr_i) begin
            next_r.wdt = 16'h0000;
        end else if (rc_tick_i) begin
            next_r.wdt = ovf ? 16'h0000 : r.wdt + 16'h0001;
        end
        // power state sequencer; hardware sets win over writes
        case (r.st)
            ST_RUN: begin
                if (ovf) begin
                    next_r.sys_rst = 1'b1;
                    next_r.rst_ctrl[TIMEOUT_FLAG_BIT] = 1'b1;
                end else if (power_save_instr_i) begin
                    next_r.st = power_save_idle_i ? ST_IDLE : ST_SLEEP;
                end
            end
            ST_IDLE: begin
                if (wake_any) begin
                    next_r.st = ST_RUN;
                    next_r.resume = 1'b1;
                    next_r.rst_ctrl[IDLE_FLAG_BIT] = 1'b1;
                    if (ovf) begin
                        next_r.rst_ctrl[TIMEOUT_FLAG_BIT] = 1'b1;
                    end
                    next_r.irq_svc = irq_wake_i && !ovf && !other_reset_i;
                end
            end
            ST_SLEEP: begin
                if (wake_any) begin
                    next_r.st = ST_WAKE;
                    next_r.dly = wake_cyc;
                    next_r.rst_ctrl[SLEEP_FLAG_BIT] = 1'b1;
                    if (ovf) begin
                        next_r.rst_ctrl[TIMEOUT_FLAG_BIT] = 1'b1;
                    end
                    next_r.svc_pend = irq_wake_i && !ovf && !other_reset_i;
                end
            end
            ST_WAKE: begin
                if (r.dly > 16'h0001) begin
                    next_r.dly = r.dly - 16'h0001;
                end else if (!slow_osc || clk_ok) begin
                    next_r.st = ST_RUN;
                    next_r.resume = 1'b1;
                    next_r.irq_svc = r.svc_pend;
                end else if (clock_fail_monitor_en_i) begin
                    next_r.st = ST_RUN;
                    next_r.trap = 1'b1;
                    next_r.osc_sel = OSC_FAST_RC;
                    next_r.cf = 1'b1;
                    next_r.resume = 1'b1;
                end else begin
                    next_r.st = ST_STALL;
                end
            end
            ST_STALL: begin
                if (clk_ok) begin
                    next_r.st = ST_RUN;
                    next_r.resume = 1'b1;
                    next_r.irq_svc = r.svc_pend;
                end
            end
            default: next_r.st = ST_RUN;
        endcase
    end

    always_ff @(posedge clock_i or negedge srst_n) begin
        if (!srst_n) begin
            r <= REG_RESET;
        end else if (ce_i) begin
            r <= next_r;
        end
    end

    // ****************************************************
    // outputs
    // ****************************************************
    assign sfr_rdata_o = r.rdata;
    assign cpu_clk_en_o = (r.st == ST_RUN);
    assign periph_clk_en_o = (r.st == ST_RUN) || (r.st == ST_IDLE);
    assign osc_en_o = (r.st != ST_SLEEP);
    assign low_power_rc_en_o = wdt_en
        || (clock_fail_monitor_en_i && r.st != ST_SLEEP);
    assign clock_fail_monitor_active_o = clock_fail_monitor_en_i
        && periph_clk_en_o;
    assign wake_osc_o = r.osc_sel;
    assign module_clk_en_o = ~r.mdis_eff & PERIPH_PRESENT
        & {32{periph_clk_en_o}};
    assign lowvolt_enable_o = r.rst_ctrl[LOWVOLT_ENABLE_BIT];
    assign lowvolt_level_o = r.rst_ctrl[LOWVOLT_LEVEL_LSB +: 4];
    assign device_reset_o = r.sys_rst;
    assign clock_fail_trap_o = r.trap;
    assign resume_o = r.resume;
    assign irq_service_o = r.irq_svc;

    // ****************************************************
    // assertions
    // ****************************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!srst_n);

    sequence s_sleep_exit;
        r.st == ST_SLEEP ##1 r.st == ST_WAKE;
    endsequence

    sequence s_held_dark;
        !cpu_clk_en_o [*8];
    endsequence

    a_wdt_run_reset: assert property (
        ce_i && ovf && r.st == ST_RUN |=> device_reset_o
            && r.rst_ctrl[TIMEOUT_FLAG_BIT])
        else $error("watchdog overflow did not reset");
    a_wdt_sleep_wake: assert property (
        ce_i && ovf && r.st == ST_SLEEP |=> r.st == ST_WAKE
            && r.rst_ctrl[SLEEP_FLAG_BIT] && r.rst_ctrl[TIMEOUT_FLAG_BIT]
            && !device_reset_o)
        else $error("watchdog overflow in sleep mishandled");
    a_sleep_clk_off: assert property (
        r.st == ST_SLEEP |-> !cpu_clk_en_o && !periph_clk_en_o
            && !osc_en_o && module_clk_en_o == 32'h0)
        else $error("clock running in sleep");
    a_wake_delay_min: assert property (
        s_sleep_exit |-> s_held_dark)
        else $error("cpu clock before wake delay");
    a_idle_resume: assert property (
        ce_i && r.st == ST_IDLE && wake_any |=> cpu_clk_en_o && resume_o
            && r.rst_ctrl[IDLE_FLAG_BIT])
        else $error("idle wake not immediate");
    a_wdt_clear: assert property (
        ce_i && watchdog_clear_instr_i |=> r.wdt == 16'h0000)
        else $error("watchdog clear ignored");
    a_fuse_enable: assert property (
        watchdog_config_word_i[WATCHDOG_FUSE_ENABLE_BIT] |-> low_power_rc_en_o)
        else $error("fused watchdog clock off");
    a_module_delay: assert property (
        ce_i && sfr_we_i && sfr_addr_i == MODULE_DISABLE1_ADDR ##1 ce_i
            |=> r.mdis_eff[15:0] == $past(sfr_wdata_i, 2))
        else $error("module disable delay wrong");
    a_stall_dark: assert property (
        r.st == ST_STALL |-> !cpu_clk_en_o ##1 (r.st == ST_STALL
            || $past(clk_ok)))
        else $error("stall left without clock");
endmodule
`default_nettype wire

//--- bench/watchdog_power_save_control_bench.sv
`timescale 1ns/100ps
`default_nettype none
module watchdog_power_save_control_bench
    import wpsc_pkg::*;
;
    // ****************************************************
    // signals
    // ****************************************************
    logic clock_i = 1'b0;
    logic rstn_i = 1'b0;
    logic ce_i = 1'b1;
    logic [15:0] sfr_addr_i = 16'h0000;
    logic [15:0] sfr_wdata_i = 16'h0000;
    logic sfr_we_i = 1'b0;
    logic sfr_re_i = 1'b0;
    logic [15:0] sfr_rdata_o;
    logic [23:0] watchdog_config_word_i = 24'h000000;
    logic [23:0] oscillator_config_word_i = 24'h000200;
    logic watchdog_clear_instr_i = 1'b0;
    logic power_save_instr_i = 1'b0;
    logic power_save_idle_i = 1'b0;
    logic irq_wake_i = 1'b0;
    logic other_reset_i = 1'b0;
    logic rc_tick_i = 1'b0;
    logic clock_switch_en_i = 1'b0;
    logic clock_fail_monitor_en_i = 1'b1;
    logic osc_stable_i = 1'b1;
    logic pll_used_i = 1'b0;
    logic pll_lock_i = 1'b0;
    logic cpu_clk_en_o, periph_clk_en_o, osc_en_o, low_power_rc_en_o;
    logic clock_fail_monitor_active_o, device_reset_o, clock_fail_trap_o;
    logic resume_o, irq_service_o, lowvolt_enable_o;
    logic [1:0] wake_osc_o;
    logic [31:0] module_clk_en_o;
    logic [3:0] lowvolt_level_o;
    int err_total = 0;
    int total_checks = 0;
    int rst_seen = 0;
    logic [15:0] rd;
    wpsc_top #(.WDT_PERIOD(16'h0004), .PERIPH_PRESENT(32'hFFFFFFFF)) DUT (
        .clock_i(clock_i), .rstn_i(rstn_i), .ce_i(ce_i),
        .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i),
        .sfr_we_i(sfr_we_i), .sfr_re_i(sfr_re_i), .sfr_rdata_o(sfr_rdata_o),
        .watchdog_config_word_i(watchdog_config_word_i),
        .oscillator_config_word_i(oscillator_config_word_i),
        .watchdog_clear_instr_i(watchdog_clear_instr_i),
        .power_save_instr_i(power_save_instr_i),
        .power_save_idle_i(power_save_idle_i), .irq_wake_i(irq_wake_i),
        .other_reset_i(other_reset_i), .rc_tick_i(rc_tick_i),
        .clock_switch_en_i(clock_switch_en_i),
        .clock_fail_monitor_en_i(clock_fail_monitor_en_i),
        .osc_stable_i(osc_stable_i), .pll_used_i(pll_used_i),
        .pll_lock_i(pll_lock_i), .cpu_clk_en_o(cpu_clk_en_o),
        .periph_clk_en_o(periph_clk_en_o), .osc_en_o(osc_en_o),
        .low_power_rc_en_o(low_power_rc_en_o),
        .clock_fail_monitor_active_o(clock_fail_monitor_active_o),
        .wake_osc_o(wake_osc_o), .module_clk_en_o(module_clk_en_o),
        .lowvolt_enable_o(lowvolt_enable_o),
        .lowvolt_level_o(lowvolt_level_o), .device_reset_o(device_reset_o),
        .clock_fail_trap_o(clock_fail_trap_o), .resume_o(resume_o),
        .irq_service_o(irq_service_o)
    );
    initial begin
        forever #20 clock_i = ~clock_i;
    end
    always @(negedge clock_i) begin
        if (device_reset_o === 1'b1) rst_seen++;
    end
    // ****************************************************
    // shared tasks
    // ****************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: %s seen %0h expected %0h", $time,
                     what, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clock_i);
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        sfr_addr_i = a;
        sfr_wdata_i = d;
        sfr_we_i = 1'b1;
        cyc(1);
        sfr_we_i = 1'b0;
    endtask
    task automatic rdreg(input logic [15:0] a);
        sfr_addr_i = a;
        sfr_re_i = 1'b1;
        cyc(1);
        sfr_re_i = 1'b0;
        cyc(1);
        rd = sfr_rdata_o;
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            rc_tick_i = 1'b1;
            cyc(1);
            rc_tick_i = 1'b0;
            cyc(1);
        end
    endtask
    task automatic pulse_clear();
        watchdog_clear_instr_i = 1'b1;
        cyc(1);
        watchdog_clear_instr_i = 1'b0;
    endtask
    task automatic enter_save(input logic idle);
        power_save_idle_i = idle;
        power_save_instr_i = 1'b1;
        cyc(1);
        power_save_instr_i = 1'b0;
        cyc(2);
    endtask
    // ****************************************************
    // scenarios
    // ****************************************************
    task automatic t_reset_values();
        rdreg(RESET_CONTROL_REG_ADDR);
        check(rd, 16'h0003, "reset control after power-on");
        check(module_clk_en_o, 32'hFFFFFFFF, "modules on by default");
        rdreg(16'h0700);
        check(rd, 16'h0000, "unmapped read");
        $display("test reset_values done");
    endtask
    task automatic t_watchdog();
        int r0;
        watchdog_config_word_i = 24'h008000;
        pulse_clear();
        r0 = rst_seen;
        tick(3);
        pulse_clear();
        tick(3);
        cyc(3);
        check(rst_seen, r0, "clear restarts count");
        tick(1);
        cyc(3);
        check(rst_seen, r0 + 1, "overflow resets in run");
        watchdog_config_word_i = 24'h000000;
        tick(8);
        cyc(3);
        check(rst_seen, r0 + 1, "fuse and soft enable off");
        wr(RESET_CONTROL_REG_ADDR, 16'h0020);
        tick(4);
        cyc(3);
        check(rst_seen, r0 + 2, "soft enable runs watchdog");
        wr(RESET_CONTROL_REG_ADDR, 16'h0000);
        $display("test watchdog done");
    endtask
    task automatic t_lowvolt();
        wr(RESET_CONTROL_REG_ADDR, 16'h3A00);
        cyc(1);
        check(lowvolt_enable_o, 1'b1, "lowvolt enable");
        check(lowvolt_level_o, 4'hA, "lowvolt level");
        cyc(520);
        rdreg(RESET_CONTROL_REG_ADDR);
        check(rd[13:8], 6'h3A, "reference stable and level");
        $display("test lowvolt done");
    endtask
    task automatic t_idle();
        int n;
        enter_save(1'b1);
        check({cpu_clk_en_o, periph_clk_en_o, osc_en_o}, 3'b011,
              "idle clocks");
        irq_wake_i = 1'b1;
        cyc(1);
        irq_wake_i = 1'b0;
        n = 0;
        while (resume_o !== 1'b1 && n < 4) begin
            cyc(1);
            n++;
        end
        check(irq_service_o, 1'b1, "idle irq service");
        check(n, 0, "idle wake without delay");
        cyc(1);
        check(cpu_clk_en_o, 1'b1, "cpu runs after idle");
        rdreg(RESET_CONTROL_REG_ADDR);
        check(rd[IDLE_FLAG_BIT], 1'b1, "idle flag");
        wr(RESET_CONTROL_REG_ADDR, 16'h1A00);
        $display("test idle done");
    endtask
    task automatic t_sleep();
        int n;
        int r0;
        watchdog_config_word_i = 24'h008000;
        pulse_clear();
        r0 = rst_seen;
        enter_save(1'b0);
        check({cpu_clk_en_o, periph_clk_en_o, osc_en_o}, 3'b000,
              "sleep clocks off");
        check(low_power_rc_en_o, 1'b1, "rc kept for watchdog");
        check(clock_fail_monitor_active_o, 1'b0, "monitor off");
        check(lowvolt_enable_o, 1'b1, "lowvolt kept in sleep");
        tick(4);
        n = 0;
        while (resume_o !== 1'b1 && n < 400) begin
            cyc(1);
            n++;
        end
        check(n >= 240 && n <= 262, 1'b1, "power-on delay only");
        check(rst_seen, r0, "no reset on sleep overflow");
        check(wake_osc_o, OSC_RC_OR_EXTERNAL, "wake oscillator");
        check(irq_service_o, 1'b0, "no service on watchdog wake");
        rdreg(RESET_CONTROL_REG_ADDR);
        check(rd[4:3], 2'b11, "timeout and sleep flags");
        watchdog_config_word_i = 24'h000000;
        $display("test sleep done");
    endtask
    task automatic t_module_disable();
        wr(MODULE_DISABLE1_ADDR, 16'h0005);
        check(module_clk_en_o[2:0], 3'b111, "disable not yet");
        cyc(1);
        check(module_clk_en_o[2:0], 3'b010, "disable after one");
        rdreg(MODULE_DISABLE1_ADDR);
        check(rd, 16'h0005, "module disable readback");
        wr(MODULE_DISABLE1_ADDR, 16'h0000);
        check(module_clk_en_o[2:0], 3'b010, "enable not yet");
        cyc(1);
        check(module_clk_en_o[2:0], 3'b111, "enable after one");
        $display("test module_disable done");
    endtask
    task automatic t_crystal();
        int n;
        oscillator_config_word_i = 24'h000300;
        clock_fail_monitor_en_i = 1'b0;
        osc_stable_i = 1'b0;
        cyc(1);
        check(wake_osc_o, OSC_PRIMARY_CRYSTAL, "crystal selected");
        enter_save(1'b0);
        irq_wake_i = 1'b1;
        cyc(1);
        irq_wake_i = 1'b0;
        cyc(700);
        check({cpu_clk_en_o, resume_o, clock_fail_trap_o}, 3'b000,
              "stall until clock");
        osc_stable_i = 1'b1;
        cyc(1);
        check({resume_o, irq_service_o}, 2'b11, "irq wake serviced");
        clock_switch_en_i = 1'b1;
        clock_fail_monitor_en_i = 1'b1;
        osc_stable_i = 1'b0;
        enter_save(1'b0);
        irq_wake_i = 1'b1;
        cyc(1);
        irq_wake_i = 1'b0;
        n = 0;
        while (clock_fail_trap_o !== 1'b1 && n < 800) begin
            cyc(1);
            n++;
        end
        check(n, POWER_ON_CYC + POWERUP_CYC, "crystal wake delay");
        check({resume_o, wake_osc_o}, 3'b100, "trap to fast rc");
        rdreg(OSC_CONTROL_REG_ADDR);
        check(rd[CLOCK_FAIL_BIT], 1'b1, "clock fail flag");
        osc_stable_i = 1'b1;
        clock_switch_en_i = 1'b0;
        $display("test crystal done");
    endtask
    // ****************************************************
    // main sequence and watchdog
    // ****************************************************
    initial begin
        cyc(10);
        rstn_i = 1'b1;
        cyc(4);
        t_reset_values();
        t_watchdog();
        t_lowvolt();
        t_idle();
        t_sleep();
        t_module_disable();
        t_crystal();
        test_done();
    end
    initial begin
        #2000000;
        err_total++;
        $display("MISMATCH at %0t: run did not finish", $time);
        test_done();
    end
endmodule
`default_nettype wire
